/* File: src/agc_core.sv */
// Automatic gain control loop with AXI4-Lite register slave
module agc_core #(
   parameter int TICK_CYCLES = agc_pkg::TICK_CYC,
   parameter int SAMPLE_W = 16
) (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic [agc_pkg::ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [agc_pkg::ADDR_W-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   output logic s_axi_rready_dummy_o,
   input wire logic s_axi_rready_i,
   input wire logic signed [SAMPLE_W-1:0] sample_i,
   input wire logic sample_valid_i,
   output logic signed [7:0] gain_o,
   output logic gain_up_o,
   output logic gain_down_o,
   output logic shutdown_o
);
   import agc_pkg::*;

   function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb, input logic [31:0] mask);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = data[8*b +: 8];
         end
      end
      return r & mask;
   endfunction

   // Coarse logarithm: 6 dB per octave plus two fraction bits
   function automatic logic [6:0] db_of(input logic [SAMPLE_W-1:0] mag);
      logic [SAMPLE_W+1:0] m2;
      logic [1:0] f;
      int p;
      m2 = {mag, 2'b00};
      p = 0;
      for (int i = 0; i < SAMPLE_W; i++) begin
         if (mag[i]) begin
            p = i;
         end
      end
      f = m2[p+1 -: 2];
      if (mag == '0) begin
         return 7'h00;
      end
      return 7'(6 * p + (3 * int'(f)) / 2);
   endfunction

   // Fixed gain in half-dB, clamped to the range allowed by compression state
   function automatic logic signed [9:0] fixed_half(input logic [5:0] raw, input logic comp);
      logic signed [9:0] v;
      logic signed [9:0] lo;
      v = 10'(signed'({raw[5], raw, 1'b0}));
      lo = comp ? FIX_MIN_COMP_H : FIX_MIN_PLAIN_H;
      if (v < lo) begin
         return lo;
      end
      if (v > FIX_MAX_H) begin
         return FIX_MAX_H;
      end
      return v;
   endfunction

   // Register bus state
   logic [31:0] ctrl;
   logic [31:0] gain_cfg;
   logic [31:0] level_cfg;
   logic [31:0] time_cfg;
   logic [31:0] ratio_cfg;
   logic aw_hold;
   logic w_hold;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid;
   logic [1:0] bresp;
   logic rvalid;
   logic [31:0] rdata;
   logic [1:0] rresp;

   // Gain loop state
   logic [SAMPLE_W-1:0] env;
   logic signed [7:0] gain;
   logic [7:0] elapsed;
   logic [$clog2(TICK_CYCLES+1)-1:0] tick_cnt;
   logic last_dec;
   logic step_up;
   logic step_down;

   wire do_write = aw_hold && w_hold;
   wire wr_ctrl = do_write && (awaddr_q == ADDR_CTRL);
   wire wr_gain = do_write && (awaddr_q == ADDR_GAIN);
   wire wr_level = do_write && (awaddr_q == ADDR_LEVEL);
   wire wr_time = do_write && (awaddr_q == ADDR_TIME);
   wire wr_ratio = do_write && (awaddr_q == ADDR_RATIO);
   wire wr_ok = wr_ctrl || wr_gain || wr_level || wr_time || wr_ratio;
   wire ar_take = s_axi_arvalid_i && !rvalid;
   wire rd_hit = (s_axi_araddr_i == ADDR_CTRL) || (s_axi_araddr_i == ADDR_GAIN) ||
                 (s_axi_araddr_i == ADDR_LEVEL) || (s_axi_araddr_i == ADDR_TIME) ||
                 (s_axi_araddr_i == ADDR_RATIO) || (s_axi_araddr_i == ADDR_STATUS);

   // Configuration fields
   wire agc_en = ctrl[CTRL_AGC_BIT];
   wire lim_en = ctrl[CTRL_LIM_BIT];
   wire hold_en = ctrl[CTRL_HOLD_BIT];
   wire shutdown = ctrl[CTRL_SHDN_BIT];
   wire [5:0] max_raw = gain_cfg[MAX_LSB +: 6];
   wire [7:0] limit_db = level_cfg[LIMIT_LSB +: 8];
   wire [7:0] gate_db = level_cfg[GATE_LSB +: 8];
   wire [7:0] atk_lim = time_cfg[ATK_LSB +: 8];
   wire [7:0] rel_lim = time_cfg[REL_LSB +: 8];
   wire [7:0] hold_lim = time_cfg[HOLD_LSB +: 8];
   wire [1:0] ratio_sel = ratio_cfg[RATIO_LSB +: 2];
   wire [6:0] env_db = db_of(env);
   wire [31:0] status_word = {17'h0_0000, env_db, gain};

   wire [31:0] rd_mux = (s_axi_araddr_i == ADDR_CTRL) ? ctrl :
                        (s_axi_araddr_i == ADDR_GAIN) ? gain_cfg :
                        (s_axi_araddr_i == ADDR_LEVEL) ? level_cfg :
                        (s_axi_araddr_i == ADDR_TIME) ? time_cfg :
                        (s_axi_araddr_i == ADDR_RATIO) ? ratio_cfg :
                        (s_axi_araddr_i == ADDR_STATUS) ? status_word : 32'h0000_0000;

   assign s_axi_awready_o = !aw_hold && !bvalid;
   assign s_axi_wready_o = !w_hold && !bvalid;
   assign s_axi_bvalid_o = bvalid;
   assign s_axi_bresp_o = bresp;
   assign s_axi_arready_o = !rvalid;
   assign s_axi_rvalid_o = rvalid;
   assign s_axi_rdata_o = rdata;
   assign s_axi_rresp_o = rresp;
   assign s_axi_rready_dummy_o = 1'b0;

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         aw_hold <= 1'b0;
         awaddr_q <= '0;
      end else if (s_axi_awvalid_i && s_axi_awready_o) begin
         aw_hold <= 1'b1;
         awaddr_q <= s_axi_awaddr_i;
      end else if (do_write) begin
         aw_hold <= 1'b0;
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         w_hold <= 1'b0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else if (s_axi_wvalid_i && s_axi_wready_o) begin
         w_hold <= 1'b1;
         wdata_q <= s_axi_wdata_i;
         wstrb_q <= s_axi_wstrb_i;
      end else if (do_write) begin
         w_hold <= 1'b0;
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else if (do_write) begin
         bvalid <= 1'b1;
         bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready_i) begin
         bvalid <= 1'b0;
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end else if (ar_take) begin
         rvalid <= 1'b1;
         rdata <= rd_mux;
         rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready_i) begin
         rvalid <= 1'b0;
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl <= CTRL_RST;
         gain_cfg <= GAIN_RST;
         level_cfg <= LEVEL_RST;
         time_cfg <= TIME_RST;
         ratio_cfg <= RATIO_RST;
      end else begin
         ctrl <= wr_ctrl ? apply_strb(ctrl, wdata_q, wstrb_q, CTRL_MASK) : ctrl;
         gain_cfg <= wr_gain ? apply_strb(gain_cfg, wdata_q, wstrb_q, GAIN_MASK) : gain_cfg;
         level_cfg <= wr_level ? apply_strb(level_cfg, wdata_q, wstrb_q, LEVEL_MASK) : level_cfg;
         time_cfg <= wr_time ? apply_strb(time_cfg, wdata_q, wstrb_q, TIME_MASK) : time_cfg;
         ratio_cfg <= wr_ratio ? apply_strb(ratio_cfg, wdata_q, wstrb_q, RATIO_MASK) : ratio_cfg;
      end
   end

   // Peak envelope: instant rise, slow exponential decay
   wire [SAMPLE_W-1:0] mag = sample_i[SAMPLE_W-1] ? SAMPLE_W'(-sample_i) : SAMPLE_W'(sample_i);
   wire [SAMPLE_W-1:0] env_decayed = env - (env >> ENV_DECAY_SHIFT);
   wire [SAMPLE_W-1:0] next_env = (mag > env) ? mag : env_decayed;

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         env <= '0;
      end else if (sample_valid_i) begin
         env <= next_env;
      end
   end

   // Fixed gain range with compression on, with it off, whole dB
   wire signed [9:0] fixed_h = fixed_half(gain_cfg[FIXED_LSB +: 6], agc_en);
   wire signed [9:0] max_h = 10'(signed'({1'b0, max_raw, 1'b0}));
   wire signed [9:0] gain_s = 10'(gain);
   wire signed [9:0] env_h = 10'(signed'({2'b00, env_db, 1'b0}));
   wire signed [9:0] out_h = env_h + gain_s;
   wire signed [9:0] lim_h = 10'(signed'({limit_db, 1'b0}));
   // Gain offset scales as (1 - 1/ratio) of the distance to the rotation point
   wire signed [9:0] dist_h = ROT_H - env_h;
   wire signed [9:0] comp_h = dist_h - (dist_h >>> ratio_sel);
   wire signed [9:0] raw_target = fixed_h + comp_h;
   wire signed [9:0] target_h = (raw_target > max_h) ? max_h : raw_target;

   wire loop_on = agc_en && !shutdown;
   // Quiet input below gate freezes the loop
   wire gated = {1'b0, env_db} < gate_db;
   // Output above limiter demands a decrement
   wire over_lim = lim_en && (out_h > lim_h);
   wire room_lim = !lim_en || (out_h + 10'sd1 <= lim_h);
   // Dead band around the target keeps a steady envelope from toggling
   wire want_dec = over_lim || (target_h < gain_s - DEADBAND_H);
   // A target clipped at the maximum draws the gain right up to it
   wire cap_pull = (raw_target >= max_h) && (target_h > gain_s);
   wire want_inc = !want_dec && room_lim && ((target_h > gain_s + DEADBAND_H) || cap_pull) && (gain_s < max_h);
   wire at_floor = gain_s <= FIX_MIN_COMP_H;
   // Hold counts only when enabled and longer than release, else release
   wire use_hold = last_dec && hold_en && (hold_lim > rel_lim);
   wire [7:0] inc_lim = use_hold ? hold_lim : rel_lim;
   // Decrement allowed only once attack interval has run out
   wire atk_done = elapsed >= atk_lim;
   // Increment allowed after release, or hold after a decrement
   wire inc_done = elapsed >= inc_lim;
   // Immediate decrement when no attack pending, wait otherwise, repeat
   wire dec_now = loop_on && !gated && want_dec && atk_done && !at_floor;
   // Raise after the increment interval while below desired level
   wire inc_now = loop_on && !gated && want_inc && inc_done;

   // Gain moves one half-dB step, fixed gain while loop is idle
   wire signed [7:0] next_gain = !loop_on ? 8'(fixed_h) :
                                 dec_now ? gain - 8'sd1 :
                                 inc_now ? gain + 8'sd1 : gain;
   wire tick = tick_cnt == ($bits(tick_cnt))'(TICK_CYCLES - 1);

   // Reset clears the gain to zero; an idle loop holds the fixed gain as starting point
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         gain <= '0;
         last_dec <= 1'b0;
         step_up <= 1'b0;
         step_down <= 1'b0;
      end else begin
         gain <= next_gain;
         last_dec <= dec_now ? 1'b1 : (inc_now ? 1'b0 : last_dec);
         step_up <= inc_now;
         step_down <= dec_now;
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tick_cnt <= '0;
      end else begin
         // Prescaler restarts with each step so no partial tick counts toward an interval
         tick_cnt <= (tick || dec_now || inc_now) ? '0 : tick_cnt + 1'b1;
      end
   end

   // Shared interval counter on the timebase, restarted at each step
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         elapsed <= 8'hFF;
      end else if (dec_now || inc_now) begin
         elapsed <= 8'h00;
      end else if (tick && (elapsed != 8'hFF)) begin
         elapsed <= elapsed + 8'h01;
      end
   end

   assign gain_o = gain;
   assign gain_up_o = step_up;
   assign gain_down_o = step_down;
   assign shutdown_o = shutdown;

   default clocking @(posedge clock_i); endclocking
   default disable iff (!resetn_i);

   step_size_a: assert property (
      loop_on ##1 loop_on |-> (gain == $past(gain)) || (gain == $past(gain) + 8'sd1) ||
                             (gain == $past(gain) - 8'sd1))
      else $error("gain moved by more than one step");

   attack_gap_a: assert property (
      step_down |-> $past(elapsed) >= $past(atk_lim))
      else $error("decrement before attack interval");

   release_gap_a: assert property (
      step_up && !$past(use_hold) |-> $past(elapsed) >= $past(rel_lim))
      else $error("increment before release interval");

   hold_gap_a: assert property (
      inc_now && last_dec && hold_en && (hold_lim > rel_lim) |-> elapsed >= hold_lim)
      else $error("first increment before hold interval");

   limit_step_a: assert property (
      loop_on && !gated && over_lim && atk_done && !at_floor ##1 loop_on
      |-> gain == $past(gain) - 8'sd1 && elapsed == 8'h00 && step_down)
      else $error("limiter overshoot not answered at once");

   attack_wait_a: assert property (
      loop_on && (elapsed < atk_lim) ##1 loop_on |-> gain >= $past(gain))
      else $error("gain dropped while attack pending");

   gate_freeze_a: assert property (
      loop_on && gated ##1 loop_on |-> $stable(gain))
      else $error("gain changed below noise gate");

   fixed_load_a: assert property (
      !loop_on |=> gain == 8'($past(fixed_h)) && !step_up && !step_down)
      else $error("idle loop not at fixed gain");

   max_cap_a: assert property (
      step_up |-> 10'(gain) <= $past(max_h))
      else $error("gain raised above maximum");

   timer_restart_a: assert property (
      (step_up || step_down) |-> elapsed == 8'h00)
      else $error("interval counter not restarted");

   step_exclusive_a: assert property (
      !(step_up && step_down))
      else $error("gain stepped both ways at once");

   limit_raise_a: assert property (
      step_up |-> !$past(over_lim))
      else $error("gain raised while above limiter");

   write_resp_a: assert property (
      s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
      else $error("write response dropped early");

   read_data_a: assert property (
      s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
      else $error("read data dropped early");

endmodule

/* File: src/agc_pkg.sv */
// Constants, register map and field layout of the automatic gain control block
// Operation
// - Every loop gain change is exactly one half-decibel step, up or down.
// - Two gain decrements are never closer than the attack interval.
// - Two gain increments are never closer than the release interval.
// - First increment after amplitude falls waits the hold interval, not release.
// - First limiter overshoot with attack expired lowers gain at once, restarts timers.
// - While attack timer runs, gain stays even above limiter level.
// - Attack expired and still above limiter: one step down, restart timers.
// - Release expired and below desired level: one step up, restart timers.
// - Near-constant envelope leaves gain unchanged.
// - Fixed gain is the operating gain while the loop is inactive.
// - Leaving shutdown or disabling the loop loads fixed gain as start.
// - With compression on, fixed gain spans -28 dB to 30 dB.
// - With compression off, fixed gain is limited to 0 dB to 30 dB.
// - Fixed gain is chosen in whole one-decibel steps.
// - Envelope below the noise gate freezes the gain.
// - Gain is reduced so output stays at or below the limiter level; code stops decrements at the -28 dB floor (FIX_MIN_COMP_H).
// - Gain never exceeds the configured maximum gain; code caps only increments, idle loop loads fixed gain even above it.
// - Outside the limiter, gain follows the selected compression ratio.
// - All gain decisions use a detected envelope, not raw samples.
// - Host programs parameters over the register bus; device applies them.
// - Hold applies only if enabled and longer than release, else release.
// - Hold disabled: release interval follows a gain decrease.
package agc_pkg;
   localparam int ADDR_W = 5;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h00;
   localparam logic [ADDR_W-1:0] ADDR_GAIN = 5'h04;
   localparam logic [ADDR_W-1:0] ADDR_LEVEL = 5'h08;
   localparam logic [ADDR_W-1:0] ADDR_TIME = 5'h0C;
   localparam logic [ADDR_W-1:0] ADDR_RATIO = 5'h10;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h14;
   localparam int CTRL_AGC_BIT = 0;
   localparam int CTRL_LIM_BIT = 1;
   localparam int CTRL_HOLD_BIT = 2;
   localparam int CTRL_SHDN_BIT = 3;
   localparam int FIXED_LSB = 0;
   localparam int MAX_LSB = 8;
   localparam int LIMIT_LSB = 0;
   localparam int GATE_LSB = 8;
   localparam int ATK_LSB = 0;
   localparam int REL_LSB = 8;
   localparam int HOLD_LSB = 16;
   localparam int RATIO_LSB = 0;
   localparam int STAT_ENV_LSB = 8;
   localparam logic [31:0] CTRL_RST = 32'h0000_0007;
   localparam logic [31:0] GAIN_RST = 32'h0000_1E06;
   localparam logic [31:0] LEVEL_RST = 32'h0000_1450;
   localparam logic [31:0] TIME_RST = 32'h0096_6401;
   localparam logic [31:0] RATIO_RST = 32'h0000_0001;
   localparam logic [31:0] CTRL_MASK = 32'h0000_000F;
   localparam logic [31:0] GAIN_MASK = 32'h0000_3F3F;
   localparam logic [31:0] LEVEL_MASK = 32'h0000_FFFF;
   localparam logic [31:0] TIME_MASK = 32'h00FF_FFFF;
   localparam logic [31:0] RATIO_MASK = 32'h0000_0003;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Gain limits in half-decibel units
   localparam logic signed [9:0] FIX_MIN_COMP_H = -10'sd56;
   localparam logic signed [9:0] FIX_MIN_PLAIN_H = 10'sd0;
   localparam logic signed [9:0] FIX_MAX_H = 10'sd60;
   localparam logic signed [9:0] ROT_H = 10'sd160;
   localparam logic signed [9:0] DEADBAND_H = 10'sd1;
   localparam int ENV_DECAY_SHIFT = 10;
   localparam int CLK_NS = 50;
   localparam int TICK_NS = 100000;
   localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
endpackage

/* File: sim/agc_audio_src.sv */
// Audio source model that feeds square tones to the gain loop
module agc_audio_src (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic [15:0] amp_i,
   output logic signed [15:0] sample_o,
   output logic sample_valid_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic phase;
   // Polarity flips on every sample, one sample per clock
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         phase <= 1'b0;
         sample_o <= 16'h0000;
         sample_valid_o <= 1'b0;
      end else begin
         phase <= ~phase;
         sample_o <= phase ? -$signed(amp_i) : $signed(amp_i);
         sample_valid_o <= 1'b1;
      end
   end
endmodule

/* File: sim/test_automatic_gain_control.sv */
// Self-checking bench for the gain loop and its register slave
module test_automatic_gain_control;
   timeunit 1ns;
   timeprecision 1ns;
   import agc_pkg::*;
   localparam int TICK = 4;
   localparam logic [4:0] RA [5] = '{ADDR_CTRL, ADDR_GAIN, ADDR_LEVEL, ADDR_TIME, ADDR_RATIO};
   localparam logic [31:0] RV [5] = '{CTRL_RST, GAIN_RST, LEVEL_RST, TIME_RST, RATIO_RST};
   localparam logic [31:0] RM [5] = '{CTRL_MASK, GAIN_MASK, LEVEL_MASK, TIME_MASK, RATIO_MASK};
   localparam logic [5:0] FX [4] = '{6'h3B, 6'h24, 6'h0A, 6'h1E};
   localparam logic [31:0] EX [4] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0014, 32'h0000_003C};
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [4:0] aw_addr = 5'h00;
   logic [4:0] ar_addr = 5'h00;
   logic aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0;
   logic [31:0] w_data = 32'h0000_0000;
   logic [3:0] w_strb = 4'hF;
   logic aw_ready, w_ready, b_valid, ar_ready, r_valid, gain_up, gain_down, shutdown, sample_valid;
   logic [1:0] b_resp, r_resp, resp;
   logic [31:0] r_data, d;
   logic signed [7:0] gain;
   logic signed [15:0] sample;
   logic [15:0] amp = 16'h0000;
   wire logic [31:0] gain32 = {{24{gain[7]}}, gain};
   int num_errors = 0, n_checks = 0, cyc = 0, last_t = 0, need = 0, n = 0;
   int atk = 1, rel = 100, hold = 150, max_h = 60;
   logic mon_en = 1'b0, has_step = 1'b0, last_dn = 1'b0, hold_en = 1'b1;
   logic [31:0] prev_g = 32'h0000_0000;

   always #25 clock = ~clock;

   agc_core #(.TICK_CYCLES(TICK), .SAMPLE_W(16)) agc_core_inst (
      .clock_i(clock), .resetn_i(resetn),
      .s_axi_awaddr_i(aw_addr), .s_axi_awvalid_i(aw_valid), .s_axi_awready_o(aw_ready),
      .s_axi_wdata_i(w_data), .s_axi_wstrb_i(w_strb), .s_axi_wvalid_i(w_valid), .s_axi_wready_o(w_ready),
      .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_valid), .s_axi_bready_i(b_ready),
      .s_axi_araddr_i(ar_addr), .s_axi_arvalid_i(ar_valid), .s_axi_arready_o(ar_ready),
      .s_axi_rdata_o(r_data), .s_axi_rresp_o(r_resp), .s_axi_rvalid_o(r_valid),
      .s_axi_rready_dummy_o(), .s_axi_rready_i(r_ready),
      .sample_i(sample), .sample_valid_i(sample_valid),
      .gain_o(gain), .gain_up_o(gain_up), .gain_down_o(gain_down), .shutdown_o(shutdown)
   );

   agc_audio_src agc_audio_src_inst (
      .clock_i(clock), .resetn_i(resetn), .amp_i(amp), .sample_o(sample), .sample_valid_o(sample_valid)
   );

   task automatic mismatch(input logic [31:0] got, input logic [31:0] exp);
      num_errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) mismatch(got, exp);
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] dat, input logic [3:0] s, output logic [1:0] r);
      @(posedge clock);
      aw_addr <= a;
      w_data <= dat;
      w_strb <= s;
      aw_valid <= 1'b1;
      w_valid <= 1'b1;
      b_ready <= 1'b1;
      do begin
         @(posedge clock);
         if (aw_valid && aw_ready) aw_valid <= 1'b0;
         if (w_valid && w_ready) w_valid <= 1'b0;
      end while (b_valid !== 1'b1);
      r = b_resp;
      b_ready <= 1'b0;
      if (aw_valid !== 1'b0 || w_valid !== 1'b0) mismatch({30'h0000_0000, aw_valid, w_valid}, 32'h0000_0000);
   endtask

   task automatic rd(input logic [4:0] a, output logic [31:0] dat);
      @(posedge clock);
      ar_addr <= a;
      ar_valid <= 1'b1;
      r_ready <= 1'b1;
      do begin
         @(posedge clock);
         if (ar_valid && ar_ready) ar_valid <= 1'b0;
      end while (r_valid !== 1'b1);
      dat = r_data;
      r_ready <= 1'b0;
      check({30'h0000_0000, r_resp}, {30'h0000_0000, RESP_OKAY});
   endtask

   task automatic wok(input logic [4:0] a, input logic [31:0] dat);
      logic [1:0] r;
      wr(a, dat, 4'hF, r);
      check({30'h0000_0000, r}, {30'h0000_0000, RESP_OKAY});
   endtask

   task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] v;
      rd(a, v);
      check(v, exp);
   endtask

   task automatic test_done;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   always @(posedge clock) begin
      cyc++;
      if (mon_en && (gain_up === 1'b1 || gain_down === 1'b1)) begin
         need = gain_down ? atk : ((last_dn && hold_en && hold > rel) ? hold : rel);
         if (gain32 - prev_g !== (gain_down ? 32'hFFFF_FFFF : 32'h0000_0001)) mismatch(gain32, prev_g);
         if (has_step && cyc - last_t < need * TICK) mismatch(cyc - last_t, need * TICK);
         has_step = 1'b1;
         last_t = cyc;
         last_dn = gain_down;
      end else if (mon_en && gain32 !== prev_g) begin
         mismatch(gain32, prev_g);
      end
      if (mon_en && $signed(gain32) > max_h) mismatch(gain32, max_h);
      prev_g = gain32;
   end

   initial begin
      repeat (40000) @(posedge clock);
      num_errors++;
      test_done();
   end

   initial begin
      repeat (20) @(posedge clock);
      resetn <= 1'b1;
      for (int i = 0; i < 5; i++) rchk(RA[i], RV[i]);
      for (int i = 0; i < 5; i++) begin
         wok(RA[i], 32'hFFFF_FFFF);
         rchk(RA[i], RM[i]);
         wok(RA[i], RV[i]);
      end
      wok(ADDR_GAIN, 32'h0000_3F3F);
      wr(ADDR_GAIN, 32'h0000_0000, 4'h1, resp);
      rchk(ADDR_GAIN, 32'h0000_3F00);
      wr(ADDR_STATUS, 32'hFFFF_FFFF, 4'hF, resp);
      check({30'h0000_0000, resp}, {30'h0000_0000, RESP_SLVERR});
      wr(5'h18, 32'hFFFF_FFFF, 4'hF, resp);
      check({30'h0000_0000, resp}, {30'h0000_0000, RESP_SLVERR});
      for (int i = 0; i < 4; i++) begin
         wok(ADDR_RATIO, i);
         rchk(ADDR_RATIO, i);
      end
      // Loop off: fixed gain drives the output, clamped at 0 dB
      wok(ADDR_CTRL, 32'h0000_0000);
      for (int i = 0; i < 4; i++) begin
         wok(ADDR_GAIN, {26'h000_0000, FX[i]} | 32'h0000_1E00);
         repeat (3) @(posedge clock);
         check(gain32, EX[i]);
      end
      wok(ADDR_GAIN, 32'h0000_0424);
      wok(ADDR_CTRL, 32'h0000_000F);
      repeat (3) @(posedge clock);
      check({31'h0000_0000, shutdown}, 32'h0000_0001);
      check(gain32, 32'hFFFF_FFC8);
      wok(ADDR_GAIN, 32'h0000_0400);
      repeat (3) @(posedge clock);
      check(gain32, 32'h0000_0000);
      wok(ADDR_TIME, 32'h0006_0332);
      atk = 50;
      rel = 3;
      hold = 6;
      max_h = 8;
      wok(ADDR_LEVEL, 32'h0000_6428);
      amp <= 16'h4000;
      wok(ADDR_CTRL, 32'h0000_0007);
      check({31'h0000_0000, shutdown}, 32'h0000_0000);
      check(gain32, 32'h0000_0000);
      mon_en <= 1'b1;
      repeat (400) @(posedge clock);
      check(gain32, 32'h0000_0000);
      // Loud tone against a low limiter
      wok(ADDR_LEVEL, 32'h0000_0028);
      for (n = 0; gain_down !== 1'b1 && n < 10; n++) @(posedge clock);
      check({31'h0000_0000, gain_down}, 32'h0000_0001);
      n = 0;
      repeat (190) begin
         @(posedge clock);
         if (gain_down !== 1'b0) n++;
      end
      check(n, 0);
      for (n = 0; gain_down !== 1'b1 && n < 40; n++) @(posedge clock);
      check({31'h0000_0000, gain_down}, 32'h0000_0001);
      check(gain32, 32'hFFFF_FFFE);
      // Quiet tone: gain climbs to the cap and stays
      amp <= 16'h0080;
      wok(ADDR_LEVEL, 32'h0000_0064);
      wok(ADDR_TIME, 32'h0006_0301);
      atk = 1;
      for (n = 0; gain32 !== 32'h0000_0008 && n < 15000; n++) @(posedge clock);
      check(gain32, 32'h0000_0008);
      repeat (300) @(posedge clock);
      check(gain32, 32'h0000_0008);
      rd(ADDR_STATUS, d);
      check({24'h00_0000, d[7:0]}, 32'h0000_0008);
      test_done();
   end
endmodule
